// file: hw/asctx_pkg.sv
// Constants for the audio serial transmit block with clock options.
// Assumes a single 10 MHz system clock and a plain strobe register port.
package asctx_pkg;
   localparam int unsigned CLK_HZ = 10000000;
   localparam int unsigned SAMPLE_W = 16;
   localparam int unsigned FRAME_BITS = 2 * SAMPLE_W;
   localparam logic [7:0] OFS_MODE = 8'h00;
   localparam logic [7:0] OFS_TX_LEFT = 8'h04;
   localparam logic [7:0] OFS_TX_RIGHT = 8'h08;
   localparam logic [7:0] OFS_STATUS = 8'h0c;
   localparam logic [7:0] OFS_RX_DATA = 8'h10;
   localparam int unsigned BIT_ENABLE = 0;
   localparam int unsigned BIT_LOOPBACK = 10;
   localparam int unsigned BIT_MONO = 12;
   localparam int unsigned BIT_DMA_PER_CH = 13;
   localparam int unsigned BIT_UNDERRUN_REPEAT = 14;
   localparam int unsigned DIV_LSB = 16;
   localparam int unsigned DIV_MSB = 21;
   localparam int unsigned RATIO_LSB = 24;
   localparam int unsigned RATIO_MSB = 29;
   localparam int unsigned ST_UNDERRUN = 0;
   localparam int unsigned ST_LEFT_FULL = 1;
   localparam int unsigned ST_RIGHT_FULL = 2;
   localparam logic [31:0] MODE_RESET = 32'h0001_0000;
   localparam logic [5:0] FIELD_ZERO = 6'h00;
endpackage : asctx_pkg

// file: hw/asctx_clk_if.sv
// Interface between the transmit core and its master clock divider.
// Assumes both ends run on the system clock.
`timescale 1ns/10ps
interface asctx_clk_if;
   logic enable;
   logic [5:0] divider;
   logic master_clock;
   modport core (output enable, output divider, input master_clock);
   modport div (input enable, input divider, output master_clock);
endinterface : asctx_clk_if

// file: hw/asctx_mck_div.sv
// Master clock divider: system clock divided by divider field plus one.
// Assumes the divider field is never zero.
`timescale 1ns/10ps
module asctx_mck_div (
   input wire logic i_clk_sys,
   input wire logic i_rst,
   asctx_clk_if.div clk_if
);
   logic [5:0] cnt_r;
   logic [6:0] half;

   assign half = {1'b0, clk_if.divider} + 7'h01;

   // Period of divider plus one input clocks
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         cnt_r <= 6'h00;
      end else if (!clk_if.enable || cnt_r >= clk_if.divider) begin
         cnt_r <= 6'h00;
      end else begin
         cnt_r <= cnt_r + 6'h01;
      end
   end

   // High for the first half of each period
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         clk_if.master_clock <= 1'b0;
      end else begin
         clk_if.master_clock <= clk_if.enable && ({1'b0, cnt_r} < (half >> 1));
      end
   end
endmodule : asctx_mck_div

// file: hw/asctx_top.sv
// Audio serial transmitter with master clock, mono, underrun and loopback options.
// Assumes a plain register port and an external codec on the serial lines.
`timescale 1ns/10ps
module asctx_top (
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic [7:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [31:0] o_rdata,
   output logic o_master_clock_out,
   output logic o_word_select_line,
   output logic o_bit_clock,
   output logic o_serial_data_out,
   input wire logic i_serial_data_in,
   output logic [1:0] o_dma_req
);
   asctx_clk_if clk_if ();

   logic enable_r;
   logic loopback_r;
   logic mono_r;
   logic dma_per_ch_r;
   logic repeat_r;
   logic [5:0] div_r;
   logic [5:0] ratio_r;
   logic [15:0] hold_l_r;
   logic [15:0] hold_r_r;
   logic full_l_r;
   logic full_r_r;
   logic [15:0] prev_l_r;
   logic [15:0] prev_r_r;
   logic [15:0] sh_r;
   logic [15:0] rx_sh_r;
   logic [31:0] rx_data_r;
   logic underrun_r;
   logic [5:0] bcnt_r;
   logic [4:0] bidx_r;
   logic sdi_s1_r;
   logic sdi_s2_r;
   logic tick;
   logic load_l;
   logic load_r;
   logic wr_l;
   logic wr_r;
   logic sdi;
   logic [15:0] next_l;
   logic [15:0] next_r;
   logic underrun_evt;

   assign clk_if.enable = enable_r;
   assign clk_if.divider = div_r;
   assign o_master_clock_out = clk_if.master_clock;

   asctx_mck_div asctx_mck_div_inst (
      .i_clk_sys(i_clk_sys),
      .i_rst(i_rst),
      .clk_if(clk_if)
   );

   // Mode register
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         enable_r <= asctx_pkg::MODE_RESET[asctx_pkg::BIT_ENABLE];
         loopback_r <= asctx_pkg::MODE_RESET[asctx_pkg::BIT_LOOPBACK];
         mono_r <= asctx_pkg::MODE_RESET[asctx_pkg::BIT_MONO];
         dma_per_ch_r <= asctx_pkg::MODE_RESET[asctx_pkg::BIT_DMA_PER_CH];
         repeat_r <= asctx_pkg::MODE_RESET[asctx_pkg::BIT_UNDERRUN_REPEAT];
         div_r <= asctx_pkg::MODE_RESET[asctx_pkg::DIV_MSB:asctx_pkg::DIV_LSB];
         ratio_r <= asctx_pkg::MODE_RESET[asctx_pkg::RATIO_MSB:asctx_pkg::RATIO_LSB];
      end else if (i_wr && i_addr == asctx_pkg::OFS_MODE) begin
         enable_r <= i_wdata[asctx_pkg::BIT_ENABLE];
         loopback_r <= i_wdata[asctx_pkg::BIT_LOOPBACK];
         mono_r <= i_wdata[asctx_pkg::BIT_MONO];
         dma_per_ch_r <= i_wdata[asctx_pkg::BIT_DMA_PER_CH];
         repeat_r <= i_wdata[asctx_pkg::BIT_UNDERRUN_REPEAT];
         div_r <= i_wdata[asctx_pkg::DIV_MSB:asctx_pkg::DIV_LSB];
         ratio_r <= i_wdata[asctx_pkg::RATIO_MSB:asctx_pkg::RATIO_LSB];
      end
   end

   // Bit slot is ratio + 1 system clocks, 32 slots per frame
   assign tick = enable_r && (bcnt_r == ratio_r);

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         bcnt_r <= 6'h00;
         bidx_r <= 5'h00;
      end else if (!enable_r || tick) begin
         bcnt_r <= 6'h00;
         bidx_r <= enable_r ? bidx_r + 5'h01 : 5'h00;
      end else begin
         bcnt_r <= bcnt_r + 6'h01;
      end
   end

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         o_bit_clock <= 1'b0;
      end else begin
         o_bit_clock <= enable_r && ({1'b0, bcnt_r} < ({1'b0, ratio_r} + 7'h01) >> 1);
      end
   end

   // Sample loads at the start of each channel slot
   assign load_l = tick && bidx_r == 5'h1f;
   assign load_r = tick && bidx_r == 5'h0f;

   // Write routing for one or two DMA channels
   assign wr_l = i_wr && (dma_per_ch_r ? i_addr == asctx_pkg::OFS_TX_LEFT
                                     : (i_addr == asctx_pkg::OFS_TX_LEFT && !full_l_r));
   assign wr_r = i_wr && !mono_r && (dma_per_ch_r ? i_addr == asctx_pkg::OFS_TX_RIGHT
                                     : (i_addr == asctx_pkg::OFS_TX_LEFT && full_l_r));

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         o_dma_req <= 2'b00;
      end else if (dma_per_ch_r) begin
         o_dma_req <= {!full_r_r && !mono_r && enable_r, !full_l_r && enable_r};
      end else begin
         o_dma_req <= {1'b0, enable_r && (!full_l_r || (!full_r_r && !mono_r))};
      end
   end

   // Underrun: slot due with no sample held
   assign next_l = full_l_r ? hold_l_r : (repeat_r ? prev_l_r : 16'h0000);
   assign next_r = mono_r ? prev_l_r
                 : (full_r_r ? hold_r_r : (repeat_r ? prev_r_r : 16'h0000));
   assign underrun_evt = (load_l && !full_l_r) || (load_r && !mono_r && !full_r_r);

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         hold_l_r <= 16'h0000;
         full_l_r <= 1'b0;
      end else if (wr_l) begin
         hold_l_r <= i_wdata[15:0];
         full_l_r <= 1'b1;
      end else if (load_l) begin
         full_l_r <= 1'b0;
      end
   end

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         hold_r_r <= 16'h0000;
         full_r_r <= 1'b0;
      end else if (wr_r) begin
         hold_r_r <= i_wdata[15:0];
         full_r_r <= 1'b1;
      end else if (load_r || mono_r) begin
         full_r_r <= 1'b0;
      end
   end

   // Shifter, MSB first, word select high on right
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         sh_r <= 16'h0000;
         prev_l_r <= 16'h0000;
         prev_r_r <= 16'h0000;
         o_serial_data_out <= 1'b0;
         o_word_select_line <= 1'b0;
      end else if (!enable_r) begin
         o_serial_data_out <= 1'b0;
         o_word_select_line <= 1'b0;
      end else if (load_l) begin
         sh_r <= {next_l[14:0], 1'b0};
         prev_l_r <= next_l;
         o_serial_data_out <= next_l[15];
         o_word_select_line <= 1'b0;
      end else if (load_r) begin
         sh_r <= {next_r[14:0], 1'b0};
         prev_r_r <= next_r;
         o_serial_data_out <= next_r[15];
         o_word_select_line <= 1'b1;
      end else if (tick) begin
         sh_r <= {sh_r[14:0], 1'b0};
         o_serial_data_out <= sh_r[15];
      end
   end

   // Input synchroniser
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         sdi_s1_r <= 1'b0;
         sdi_s2_r <= 1'b0;
      end else begin
         sdi_s1_r <= i_serial_data_in;
         sdi_s2_r <= sdi_s1_r;
      end
   end

   assign sdi = loopback_r ? o_serial_data_out : sdi_s2_r;

   // Receive shifter, sampled at slot end
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         rx_sh_r <= 16'h0000;
         rx_data_r <= 32'h0000_0000;
      end else if (tick) begin
         rx_sh_r <= {rx_sh_r[14:0], sdi};
         if (bidx_r == 5'h0f) begin
            rx_data_r[31:16] <= {rx_sh_r[14:0], sdi};
         end
         if (bidx_r == 5'h1f) begin
            rx_data_r[15:0] <= {rx_sh_r[14:0], sdi};
         end
      end
   end

   // Sticky underrun flag, set wins over clear
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         underrun_r <= 1'b0;
      end else if (underrun_evt) begin
         underrun_r <= 1'b1;
      end else if (i_wr && i_addr == asctx_pkg::OFS_STATUS && i_wdata[asctx_pkg::ST_UNDERRUN]) begin
         underrun_r <= 1'b0;
      end
   end

   // Read port, data one cycle after strobe
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         o_rdata <= 32'h0000_0000;
      end else if (i_rd) begin
         case (i_addr)
            asctx_pkg::OFS_MODE: begin
               o_rdata <= {2'b00, ratio_r, 2'b00, asctx_pkg::FIELD_ZERO, 1'b0, repeat_r, dma_per_ch_r,
                           mono_r, 1'b0, loopback_r, 9'h000, enable_r};
            end
            asctx_pkg::OFS_TX_LEFT: begin
               o_rdata <= {16'h0000, hold_l_r};
            end
            asctx_pkg::OFS_TX_RIGHT: begin
               o_rdata <= {16'h0000, hold_r_r};
            end
            asctx_pkg::OFS_STATUS: begin
               o_rdata <= {29'h000_0000, full_r_r, full_l_r, underrun_r};
            end
            asctx_pkg::OFS_RX_DATA: begin
               o_rdata <= rx_data_r;
            end
            default: begin
               o_rdata <= 32'h0000_0000;
            end
         endcase
      end else begin
         o_rdata <= 32'h0000_0000;
      end
   end
endmodule : asctx_top

// file: test/asctx_asserts.sv
// Port checker for the audio serial transmitter.
// Assumes it is bound to asctx_top and sees only its ports.
`timescale 1ns/10ps
module asctx_asserts (
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic [7:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [31:0] o_rdata,
   input wire logic o_master_clock_out,
   input wire logic o_word_select_line,
   input wire logic [1:0] o_dma_req
);
   logic [31:0] mode_r;
   logic [7:0] quiet_r;
   logic [7:0] mck_cnt_r;
   logic [11:0] ws_cnt_r;
   // Mode shadow and cycles since last mode write
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         mode_r <= asctx_pkg::MODE_RESET;
         quiet_r <= 8'h00;
      end else if (i_wr && i_addr == asctx_pkg::OFS_MODE) begin
         mode_r <= i_wdata;
         quiet_r <= 8'h00;
      end else if (quiet_r != 8'hff) begin
         quiet_r <= quiet_r + 8'h01;
      end
   end
   // Cycles since last clock rise and last slot change
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         mck_cnt_r <= 8'h00;
         ws_cnt_r <= 12'h000;
      end else begin
         mck_cnt_r <= $rose(o_master_clock_out) ? 8'h01 : mck_cnt_r + 8'h01;
         ws_cnt_r <= $changed(o_word_select_line) ? 12'h001 : ws_cnt_r + 12'h001;
      end
   end
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);
   rd_fields_a: assert property (i_rd && i_addr == asctx_pkg::OFS_MODE |=>
      o_rdata[21:16] == 6'h00 && o_rdata[29:24] == mode_r[29:24]) else $error("mode read wrong");
   rd_idle_a: assert property (!i_rd |=> o_rdata == 32'h0000_0000) else $error("read data not idle");
   rd_unmapped_a: assert property (i_rd && i_addr > asctx_pkg::OFS_RX_DATA |=> o_rdata == 32'h0000_0000)
      else $error("unmapped read nonzero");
   mck_period_a: assert property (quiet_r == 8'hff && $rose(o_master_clock_out) |->
      mck_cnt_r == {2'h0, mode_r[21:16]} + 8'h01) else $error("master clock period wrong");
   mck_high_a: assert property (quiet_r == 8'hff && $fell(o_master_clock_out) |->
      mck_cnt_r == ({2'h0, mode_r[21:16]} + 8'h01) >> 1) else $error("master clock high time wrong");
   ws_period_a: assert property (quiet_r == 8'hff && $changed(o_word_select_line) |->
      ws_cnt_r == ({6'h00, mode_r[29:24]} + 12'h001) * 12'h010) else $error("word select period wrong");
   dma_off_a: assert property (quiet_r > 8'h01 && !mode_r[0] |-> o_dma_req == 2'b00)
      else $error("request while disabled");
   dma_right_a: assert property (quiet_r > 8'h01 && (!mode_r[13] || mode_r[12]) |-> !o_dma_req[1])
      else $error("right request not allowed");
   cover property (quiet_r == 8'hff && $rose(o_master_clock_out));
   cover property (mode_r[12] && o_word_select_line);
   cover property (mode_r[13] && o_dma_req == 2'b11);
endmodule : asctx_asserts

// file: test/asctx_codec.sv
// Codec model: collects each channel's serial word and drives a toggling input line.
// Assumes data is steady in the second half of each bit slot.
`timescale 1ns/10ps
module asctx_codec (
   input wire logic i_clk_sys,
   input wire logic i_bit_clock,
   input wire logic i_word_select_line,
   input wire logic i_serial_data_out,
   output logic o_serial_data_in,
   output logic [15:0] o_left,
   output logic [15:0] o_right
);
   logic bclk_q = 1'b0;
   logic sdi_r = 1'b0;
   assign o_serial_data_in = sdi_r;
   always @(posedge i_clk_sys) begin
      bclk_q <= i_bit_clock;
      sdi_r <= !sdi_r;
      if (bclk_q && !i_bit_clock) begin
         if (i_word_select_line) begin
            o_right <= {o_right[14:0], i_serial_data_out};
         end else begin
            o_left <= {o_left[14:0], i_serial_data_out};
         end
      end
   end
endmodule : asctx_codec

// file: test/tb_top.sv
// Testbench for the audio serial transmitter with a codec model.
// Assumes a 10 MHz clock and the strobe register port.
`timescale 1ns/10ps
module tb_top;
   logic i_clk_sys = 1'b0;
   logic i_rst = 1'b1;
   logic [7:0] i_addr = 8'h00;
   logic [31:0] i_wdata = 32'h0000_0000;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic [31:0] o_rdata;
   logic o_master_clock_out, o_word_select_line, o_bit_clock, o_serial_data_out, i_serial_data_in;
   logic [1:0] o_dma_req;
   logic [15:0] lw, rw;
   int num_errors = 0;
   int comparisons = 0;
   always #50 i_clk_sys = !i_clk_sys;
   asctx_top asctx_top_inst (.i_clk_sys, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
      .o_master_clock_out, .o_word_select_line, .o_bit_clock, .o_serial_data_out, .i_serial_data_in, .o_dma_req);
   asctx_codec asctx_codec_inst (.i_clk_sys, .i_bit_clock(o_bit_clock), .i_word_select_line(o_word_select_line),
      .i_serial_data_out(o_serial_data_out), .o_serial_data_in(i_serial_data_in), .o_left(lw), .o_right(rw));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clk_sys);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_clk_sys);
      i_wr <= 1'b0;
   endtask : wr
   task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp, input string msg);
      @(posedge i_clk_sys);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_clk_sys);
      i_rd <= 1'b0;
      #1 chk(o_rdata & m, exp, msg);
   endtask : rdchk
   task automatic idle(input int n);
      repeat (n) @(posedge i_clk_sys);
      #1;
   endtask : idle
   task automatic wait_ws(input logic lvl);
      int n;
      n = 0;
      while (o_word_select_line !== lvl && n < 2000) begin
         idle(1);
         n++;
      end
      if (n >= 2000) begin
         num_errors++;
         $display("unexpected %0t word select stuck", $time);
         complete_run();
      end
   endtask : wait_ws
   // Left word is whole just after the right slot starts, right word just after the left one
   task automatic chk_words(input logic [15:0] l, input logic [15:0] r, input string msg);
      wait_ws(1'b0);
      wait_ws(1'b1);
      chk({16'h0000, lw}, {16'h0000, l}, msg);
      wait_ws(1'b0);
      chk({16'h0000, rw}, {16'h0000, r}, msg);
   endtask : chk_words
   task automatic t_regs;
      rdchk(asctx_pkg::OFS_MODE, 32'hffff_ffff, 32'h0000_0000, "mode reset");
      wr(asctx_pkg::OFS_MODE, 32'h0115_7400);
      rdchk(asctx_pkg::OFS_MODE, 32'hffff_ffff, 32'h0100_7400, "mode readback");
      rdchk(8'h20, 32'hffff_ffff, 32'h0000_0000, "unmapped");
   endtask : t_regs
   task automatic t_stereo;
      wr(asctx_pkg::OFS_MODE, 32'h0101_4401);
      wr(asctx_pkg::OFS_TX_LEFT, 32'h0000_a5c3);
      wr(asctx_pkg::OFS_TX_LEFT, 32'h0000_5a3c);
      idle(1);
      chk({30'h0, o_dma_req}, 32'h0, "no request when full");
      idle(256);
      chk_words(16'ha5c3, 16'h5a3c, "stereo words");
      rdchk(asctx_pkg::OFS_RX_DATA, 32'hffff_ffff, 32'ha5c3_5a3c, "loopback");
   endtask : t_stereo
   task automatic t_under;
      wr(asctx_pkg::OFS_MODE, 32'h0101_0001);
      idle(256);
      chk_words(16'h0000, 16'h0000, "zero on underrun");
      rdchk(asctx_pkg::OFS_STATUS, 32'h0000_0001, 32'h0000_0001, "underrun flag");
      chk({30'h0, o_dma_req}, 32'h1, "single request");
      wr(asctx_pkg::OFS_MODE, 32'h0101_2001);
      idle(4);
      chk({30'h0, o_dma_req}, 32'h3, "per channel request");
      wr(asctx_pkg::OFS_MODE, 32'h0101_3001);
      idle(4);
      chk({30'h0, o_dma_req}, 32'h1, "mono request");
   endtask : t_under
   task automatic t_mono;
      // Mono without repeat: one sample, right copy must not fall back to zero
      wr(asctx_pkg::OFS_MODE, 32'h0101_1001);
      wait_ws(1'b0);
      wait_ws(1'b1);
      wr(asctx_pkg::OFS_TX_LEFT, 32'h0000_1234);
      chk_words(16'h1234, 16'h1234, "mono copy");
   endtask : t_mono
   task automatic t_rates;
      int rises;
      int flips;
      logic m;
      logic w;
      wr(asctx_pkg::OFS_MODE, 32'h0303_0001);
      idle(300);
      rises = 0;
      flips = 0;
      m = o_master_clock_out;
      w = o_word_select_line;
      repeat (256) begin
         idle(1);
         rises += int'(o_master_clock_out === 1'b1 && m === 1'b0);
         flips += int'(o_word_select_line !== w);
         m = o_master_clock_out;
         w = o_word_select_line;
      end
      chk(rises, 32'd64, "clock rises");
      chk(flips, 32'd4, "slot changes");
   endtask : t_rates
   task automatic complete_run;
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : complete_run
   initial begin
      repeat (10) @(posedge i_clk_sys);
      i_rst <= 1'b0;
      t_regs();
      t_stereo();
      t_under();
      t_mono();
      t_rates();
      complete_run();
   end
endmodule : tb_top
bind asctx_top asctx_asserts asctx_asserts_inst (.i_clk_sys, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
   .o_master_clock_out, .o_word_select_line, .o_dma_req);
